// ---- dram_ctrl.sv ----
`timescale 1ns/10ps
module dram_ctrl
  import dram_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int TICK_CYCLES = REFRESH_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic req,
  input wire logic req_write,
  input wire logic [ADDR_BITS-1:0] req_addr,
  input wire logic req_wdata,
  input wire logic rd_hold,
  output logic req_ready,
  output logic rd_valid,
  output logic rd_data,
  output logic init_done,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ROW_BITS-1:0] mem_addr,
  output logic mem_d,
  input wire logic mem_q
);
  refresh_if rif ();

  refresh_timer #(
    .POWERUP_CYCLES(POWERUP_CYCLES),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rif(rif)
  );

  // ==========================================================
  // State
  ctrl_state_t state_reg, state_next;
  logic [CNT_BITS-1:0] cnt_reg, cnt_next;
  logic [REF_ROW_BITS-1:0] row_ctr_reg, row_ctr_next;
  logic [3:0] dummy_reg, dummy_next;
  logic pend_reg, pend_next;
  logic init_reg, init_next;
  logic write_reg, write_next;
  logic [ROW_BITS-1:0] col_reg, col_next;
  logic ras_n_reg, ras_n_next;
  logic cas_n_reg, cas_n_next;
  logic we_n_reg, we_n_next;
  logic [ROW_BITS-1:0] addr_reg, addr_next;
  logic d_reg, d_next;
  logic rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic ready_reg, ready_next;
  logic ref_start;

  // ==========================================================
  // Decode
  wire logic [CNT_BITS-1:0] cnt_inc = cnt_reg + CNT_BITS'(1);
  wire logic [CNT_BITS-1:0] cnt_sat = (&cnt_reg) ? cnt_reg : cnt_inc;
  wire logic act_col = cnt_reg == CNT_BITS'(0);
  wire logic act_cas = cnt_reg == CNT_BITS'(RCD_CYC - 1);
  wire logic act_end = cnt_reg == CNT_BITS'(ACT_CYC - 1);
  wire logic ras_end = cnt_reg == CNT_BITS'(RAS_LOW_CYC - 1);
  // Covers precharge, column-to-row delay and the read hold on write strobe
  wire logic pre_done = cnt_reg >= CNT_BITS'(max2(RP_CYC, max2(CRP_CYC, RRH_CYC)) - 1);
  wire logic dummy_last = dummy_reg == 4'(DUMMY_CYCLES - 1);
  wire logic take_req = req && ready_reg;
  wire logic [ROW_BITS-1:0] ref_row = {1'b0, row_ctr_reg};

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    row_ctr_next = row_ctr_reg;
    dummy_next = dummy_reg;
    init_next = init_reg;
    write_next = write_reg;
    col_next = col_reg;
    ras_n_next = ras_n_reg;
    cas_n_next = cas_n_reg;
    we_n_next = we_n_reg;
    addr_next = addr_reg;
    d_next = d_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    ref_start = 1'b0;
    unique case (state_reg)
      ST_INIT: begin
        if (rif.powered) begin
          ras_n_next = 1'b0;
          addr_next = ref_row;
          cnt_next = '0;
          state_next = ST_REF;
        end
      end
      ST_IDLE: begin
        cnt_next = '0;
        if (!init_reg || pend_reg) begin
          ref_start = init_reg;
          ras_n_next = 1'b0;
          addr_next = ref_row;
          state_next = ST_REF;
        end else if (take_req) begin
          ras_n_next = 1'b0;
          addr_next = req_addr[ADDR_BITS-1:ROW_BITS];
          col_next = req_addr[ROW_BITS-1:0];
          write_next = req_write;
          d_next = req_wdata;
          state_next = ST_ACT;
        end
      end
      ST_ACT: begin
        cnt_next = cnt_inc;
        if (act_col) begin
          addr_next = col_reg;
          we_n_next = !write_reg; // Early write keeps the output open
        end
        if (act_cas) cas_n_next = 1'b0;
        if (act_end) begin
          ras_n_next = 1'b1;
          cnt_next = '0;
          if (!write_reg) begin
            rd_data_next = mem_q;
            rd_valid_next = 1'b1;
          end
          we_n_next = 1'b1;
          if (!write_reg && rd_hold) begin
            state_next = ST_HOLD;
          end else begin
            cas_n_next = 1'b1;
            state_next = ST_PRE;
          end
        end
      end
      ST_REF: begin
        cnt_next = cnt_inc;
        if (ras_end) begin
          ras_n_next = 1'b1;
          cnt_next = '0;
          row_ctr_next = row_ctr_reg + REF_ROW_BITS'(1);
          if (!init_reg) begin
            dummy_next = dummy_reg + 4'(1);
            if (dummy_last) init_next = 1'b1;
          end
          state_next = ST_PRE;
        end
      end
      ST_PRE: begin
        cnt_next = cnt_sat;
        if (pre_done) state_next = ST_IDLE;
      end
      ST_HOLD: begin
        cnt_next = cnt_sat;
        rd_valid_next = 1'b1;
        if (!rd_hold) begin
          cas_n_next = 1'b1;
          state_next = ST_PRE;
        end else if (pend_reg && pre_done) begin
          ref_start = 1'b1;
          ras_n_next = 1'b0;
          cnt_next = '0;
          state_next = ST_HID;
        end
      end
      ST_HID: begin
        cnt_next = cnt_inc;
        rd_valid_next = 1'b1;
        if (ras_end) begin
          ras_n_next = 1'b1;
          cnt_next = '0;
          state_next = ST_HOLD;
        end
      end
      // Eighth code of the state word is unused
      default: state_next = ST_INIT;
    endcase
    // A tick in the same cycle as a refresh start is kept
    pend_next = rif.tick || (pend_reg && !ref_start);
    ready_next = (state_next == ST_IDLE) && init_next && !pend_next && !take_req;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= ST_INIT;
      cnt_reg <= '0;
      row_ctr_reg <= '0;
      dummy_reg <= '0;
      pend_reg <= 1'b0;
      init_reg <= 1'b0;
      write_reg <= 1'b0;
      col_reg <= '0;
      ras_n_reg <= 1'b1;
      cas_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      addr_reg <= '0;
      d_reg <= 1'b0;
      rd_data_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      row_ctr_reg <= row_ctr_next;
      dummy_reg <= dummy_next;
      pend_reg <= pend_next;
      init_reg <= init_next;
      write_reg <= write_next;
      col_reg <= col_next;
      ras_n_reg <= ras_n_next;
      cas_n_reg <= cas_n_next;
      we_n_reg <= we_n_next;
      addr_reg <= addr_next;
      d_reg <= d_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      ready_reg <= ready_next;
    end
  end

  assign req_ready = ready_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  assign init_done = init_reg;
  assign ras_n = ras_n_reg;
  assign cas_n = cas_n_reg;
  assign we_n = we_n_reg;
  assign mem_addr = addr_reg;
  assign mem_d = d_reg;
endmodule // dram_ctrl

// ---- dram_ctrl_sva.sv ----
`timescale 1ns/10ps
module dram_ctrl_sva
  import dram_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rd_hold,
  input wire logic rd_valid,
  input wire logic rd_data,
  input wire logic init_done,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n
);
  // ====================
  // Row strobe falls since reset
  logic ras_q_reg;
  logic [3:0] dummy_reg;
  always_ff @(posedge clk_sys) begin
    ras_q_reg <= ras_n;
    if (!resetn) dummy_reg <= 4'h0;
    else if (ras_q_reg && !ras_n && dummy_reg != 4'hf) dummy_reg <= dummy_reg + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_ras_low_width: assert property ($fell(ras_n) |-> (!ras_n)[*5] ##1 ras_n)
    else $error("row strobe low width wrong");
  chk_ras_precharge: assert property ($rose(ras_n) |-> ras_n[*4])
    else $error("row strobe precharge too short");
  chk_rcd_window: assert property ($fell(cas_n) |-> !$past(ras_n) && $past(ras_n, 3))
    else $error("row to column delay out of window");
  chk_cas_ras_gap: assert property ($fell(ras_n) && cas_n |-> $past(cas_n, 2))
    else $error("column high too short before row");
  chk_we_read_hold: assert property ($rose(ras_n) |-> we_n ##1 we_n)
    else $error("write strobe low after row rise");
  chk_hold_data: assert property (rd_valid && rd_hold |=> rd_valid && !cas_n && $stable(rd_data))
    else $error("held read data lost");
  chk_hidden_shape: assert property ($fell(ras_n) && !cas_n |-> rd_valid && (!cas_n)[*5])
    else $error("hidden refresh without held data");
  chk_ready_init: assert property (!init_done |-> !req_ready)
    else $error("ready before init");
  chk_dummy_count: assert property ($rose(init_done) |-> dummy_reg >= 4'h8)
    else $error("too few dummy cycles");
  chk_read_answer: assert property (req && req_ready && !req_write |-> ##[5:8] $rose(rd_valid))
    else $error("read answer late");
endmodule // dram_ctrl_sva
bind dram_ctrl dram_ctrl_sva dram_ctrl_sva_inst (.clk_sys(clk_sys), .resetn(resetn), .req(req),
  .req_write(req_write), .req_ready(req_ready), .rd_hold(rd_hold), .rd_valid(rd_valid),
  .rd_data(rd_data), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));

// ---- dram_ctrl_tb.sv ----
`timescale 1ns/10ps
module dram_ctrl_tb;
  import dram_pkg::*;
  localparam int TICK = 40;
  localparam int PU = 20;
  // Power-up wait plus the shortest dummy row cycles
  localparam int INIT_MIN = PU + DUMMY_CYCLES * (RAS_LOW_CYC + RP_CYC);
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_wdata = 1'b0;
  logic rd_hold = 1'b0;
  logic [ADDR_BITS-1:0] req_addr = 18'h0;
  logic req_ready, rd_valid, rd_data, init_done, ras_n, cas_n, we_n, mem_d, mem_q, v_q;
  logic [ROW_BITS-1:0] mem_addr;
  logic [ADDR_BITS-1:0] addrs [8];
  logic ref_mem [logic [ADDR_BITS-1:0]];
  logic exp_q [$];
  logic [255:0] seen = 256'h0;
  int error_cnt = 0;
  int checks = 0;
  int seed = 81108;
  int falls = 0;
  int hid = 0;
  int t0;
  bit track = 0;
  always #12.5 clk_sys = ~clk_sys;
  dram_ctrl #(.POWERUP_CYCLES(PU), .TICK_CYCLES(TICK)) dram_ctrl_inst (.clk_sys(clk_sys),
    .resetn(resetn), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_hold(rd_hold), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .mem_addr(mem_addr), .mem_d(mem_d), .mem_q(mem_q));
  dram_model dram_model_inst (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .mem_addr(mem_addr), .mem_d(mem_d), .mem_q(mem_q));
  task automatic check_bit(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected bit at %0t: exp %0h got %0h", $time, exp, got);
    end
  endtask
  task automatic check_cnt(input int exp, input int got);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected count at %0t: exp %0h got %0h", $time, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_sig(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      @(negedge clk_sys);
      n++;
      if (n > 3000) begin
        error_cnt++;
        report_and_stop();
      end
    end
  endtask
  // Called at a falling edge; the gap keeps one request per take
  task automatic access(input logic wr, input logic [ADDR_BITS-1:0] a, input logic d);
    wait_sig(req_ready, 1'b1);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    if (wr) ref_mem[a] = d;
    else exp_q.push_back(ref_mem[a]);
    @(negedge clk_sys);
    req = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // ====================
  // Result watcher
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1 && v_q !== 1'b1) begin
      if (exp_q.size() == 0) check_bit(1'bx, rd_data);
      else check_bit(exp_q.pop_front(), rd_data);
    end
    v_q = rd_valid;
  end
  always @(negedge ras_n) begin
    // Address register updates in the same step as the strobe
    #1;
    falls++;
    if (cas_n === 1'b0) hid++;
    if (track) seen[mem_addr[7:0]] = 1'b1;
  end
  // ====================
  // Main sequence
  initial begin
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    t0 = $time;
    wait_sig(init_done, 1'b1);
    check_cnt(1, int'(falls >= DUMMY_CYCLES));
    check_cnt(1, int'(($time - t0) / CLK_PERIOD_NS >= INIT_MIN));
    $display("test powerup done");
    for (int i = 0; i < 8; i++) begin
      addrs[i] = (i == 0) ? 18'h0 : (i == 7) ? 18'h3ffff : 18'($random(seed));
      access(1'b1, addrs[i], 1'($random(seed)));
    end
    for (int i = 0; i < 8; i++) access(1'b0, addrs[i], 1'b0);
    repeat (20) @(negedge clk_sys);
    check_cnt(0, exp_q.size());
    $display("test access done");
    rd_hold = 1'b1;
    t0 = hid;
    access(1'b0, addrs[3], 1'b0);
    repeat (6 * TICK) @(negedge clk_sys);
    check_cnt(1, int'(hid - t0 >= 4));
    check_bit(1'b1, rd_valid);
    check_bit(ref_mem[addrs[3]], rd_data);
    check_bit(ref_mem[addrs[3]], mem_q);
    rd_hold = 1'b0;
    wait_sig(rd_valid, 1'b0);
    $display("test hidden refresh done");
    track = 1;
    repeat (258 * TICK) @(negedge clk_sys);
    track = 0;
    check_cnt(256, $countones(seen));
    $display("test refresh sweep done");
    report_and_stop();
  end
endmodule // dram_ctrl_tb

// ---- dram_model.sv ----
`timescale 1ns/10ps
module dram_model
  import dram_pkg::*;
#(
  parameter int ACC_NS = COLUMN_ACCESS_TIME_NS
) (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_BITS-1:0] mem_addr,
  input wire logic mem_d,
  output logic mem_q
);
  // ====================
  // Cell array and latches
  logic cells [logic [ADDR_BITS-1:0]];
  logic [ROW_BITS-1:0] row_reg = 9'h0;
  logic [REF_ROW_BITS-1:0] ref_cnt_reg = 8'h0;
  logic q_reg = 1'b0;
  logic drive_reg = 1'b0;
  // Open output shows the inverse, never a stale bit
  assign mem_q = drive_reg ? q_reg : ~q_reg;
  // Latch 1 ns after the strobe, inside the address hold time
  always @(negedge ras_n) begin
    #1;
    if (cas_n) begin
      row_reg = mem_addr;
    end else begin
      ref_cnt_reg = ref_cnt_reg + 8'h1;
    end
  end
  always @(negedge cas_n) begin
    #1;
    if (!ras_n) begin
      if (!we_n) begin
        cells[{row_reg, mem_addr}] = mem_d;
      end else begin
        q_reg = cells.exists({row_reg, mem_addr}) ? cells[{row_reg, mem_addr}] : ~q_reg;
        #(ACC_NS - 1);
        drive_reg = !cas_n;
      end
    end
  end
  always @(posedge cas_n) drive_reg = 1'b0;
endmodule // dram_model

// ---- dram_pkg.sv ----
package dram_pkg;
  // ==========================================================
  // Clock
  localparam int CLK_PERIOD_NS = 25;

  // ==========================================================
  // Pin widths
  localparam int ROW_BITS = 9;
  localparam int ADDR_BITS = 18;
  localparam int REF_ROW_BITS = 8;
  localparam int REF_ROWS = 256;

  // ==========================================================
  // Times in their own units
  localparam int POWERUP_WAIT_US = 500;
  localparam int DUMMY_CYCLES = 8;
  localparam int REFRESH_INTERVAL_MS = 4;
  localparam int RAS_PRECHARGE_NS = 100;
  localparam int RAS_LOW_NS = 120;
  localparam int CAS_LOW_NS = 60;
  localparam int ROW_TO_COLUMN_DELAY_MIN_NS = 25;
  localparam int ROW_TO_COLUMN_DELAY_MAX_NS = 60;
  localparam int COLUMN_TO_ROW_PRECHARGE_DELAY_NS = 30;
  localparam int READ_HOLD_AFTER_ROW_NS = 20;
  localparam int ROW_ACCESS_TIME_NS = 120;
  localparam int COLUMN_ACCESS_TIME_NS = 60;

  // ==========================================================
  // Cycle counts: least times round up, longest times round down
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_down(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int POWERUP_CYC = POWERUP_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int REFRESH_TICK_CYC =
    REFRESH_INTERVAL_MS * 1000000 / REF_ROWS / CLK_PERIOD_NS;
  localparam int RP_CYC = cyc_up(RAS_PRECHARGE_NS);
  localparam int RAS_LOW_CYC = cyc_up(RAS_LOW_NS);
  localparam int CAS_LOW_CYC = cyc_up(CAS_LOW_NS);
  localparam int RCD_CYC = max2(cyc_up(ROW_TO_COLUMN_DELAY_MIN_NS),
                                cyc_down(ROW_TO_COLUMN_DELAY_MAX_NS));
  localparam int CRP_CYC = cyc_up(COLUMN_TO_ROW_PRECHARGE_DELAY_NS);
  localparam int RRH_CYC = cyc_up(READ_HOLD_AFTER_ROW_NS);
  localparam int RAC_CYC = cyc_up(ROW_ACCESS_TIME_NS);
  localparam int CAC_CYC = cyc_up(COLUMN_ACCESS_TIME_NS);
  localparam int ACT_CYC = max2(max2(RAS_LOW_CYC, RAC_CYC),
                                RCD_CYC + max2(CAS_LOW_CYC, CAC_CYC));
  localparam int CNT_BITS = 8;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_ACT, ST_REF, ST_PRE, ST_HOLD, ST_HID
  } ctrl_state_t;
endpackage

// ---- refresh_if.sv ----
`timescale 1ns/10ps
interface refresh_if;
  logic tick;
  logic powered;
  modport timer (output tick, output powered);
  modport ctrl (input tick, input powered);
endinterface

// ---- refresh_timer.sv ----
`timescale 1ns/10ps
module refresh_timer
  import dram_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int TICK_CYCLES = REFRESH_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  refresh_if.timer rif
);
  localparam int W = $clog2(POWERUP_CYCLES + TICK_CYCLES + 1);

  logic [W-1:0] cnt_reg;
  logic powered_reg;
  logic tick_reg;

  wire logic pu_done = cnt_reg == W'(POWERUP_CYCLES - 1);
  wire logic tick_done = cnt_reg == W'(TICK_CYCLES - 1);
  wire logic wrap = powered_reg ? tick_done : pu_done;

  // ==========================================================
  // Power-up wait, then one pulse per row interval
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_reg <= '0;
      powered_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + W'(1);
      if (pu_done) powered_reg <= 1'b1;
      tick_reg <= powered_reg && tick_done;
    end
  end

  assign rif.tick = tick_reg;
  assign rif.powered = powered_reg;
endmodule // refresh_timer
